// ---- rtl/smc_ctrl.v ----
// Standby mode controller with stop and halt modes and AXI4-Lite registers.
// Assumes the CPU pulses stop/halt execution and supplies request/enable flags.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "smc_map.vh"
module smc_ctrl #(
   parameter P_WAIT_20    = `SMC_WAIT_20,
   parameter P_WAIT_17    = `SMC_WAIT_17,
   parameter P_WAIT_15    = `SMC_WAIT_15,
   parameter P_WAIT_13    = `SMC_WAIT_13,
   parameter P_RESET_LONG = 1
) (
   input  wire                 i_sys_clk,
   input  wire                 i_sys_rst,
   input  wire                 i_stop_exec,
   input  wire                 i_halt_exec,
   input  wire [`SMC_NSRC-1:0] i_irq_req,
   input  wire [`SMC_NSRC-1:0] i_irq_en,
   input  wire                 i_master_irq_en,
   input  wire                 i_ser_ext_clk_sel,
   input  wire                 i_tmr_ext_clk_sel,
   input  wire [3:0]           i_s_axi_awaddr,
   input  wire                 i_s_axi_awvalid,
   output reg                  o_s_axi_awready,
   input  wire [31:0]          i_s_axi_wdata,
   input  wire [3:0]           i_s_axi_wstrb,
   input  wire                 i_s_axi_wvalid,
   output reg                  o_s_axi_wready,
   output reg  [1:0]           o_s_axi_bresp,
   output reg                  o_s_axi_bvalid,
   input  wire                 i_s_axi_bready,
   input  wire [3:0]           i_s_axi_araddr,
   input  wire                 i_s_axi_arvalid,
   output reg                  o_s_axi_arready,
   output reg  [31:0]          o_s_axi_rdata,
   output reg  [1:0]           o_s_axi_rresp,
   output reg                  o_s_axi_rvalid,
   input  wire                 i_s_axi_rready,
   output reg                  o_osc_en,
   output reg                  o_cpu_clk_en,
   output reg                  o_cpu_rst_hold,
   output reg                  o_retain,
   output reg                  o_bt_run,
   output reg                  o_ser_run,
   output reg                  o_tmr_run,
   output reg                  o_ext0_run,
   output reg                  o_resume,
   output reg                  o_vector_ok,
   output reg  [1:0]           o_cpu_clk_sel
);
   // One-hot states
   localparam [4:0] ST_RST   = 5'h01;
   localparam [4:0] ST_RUN   = 5'h02;
   localparam [4:0] ST_HALT  = 5'h04;
   localparam [4:0] ST_STOP  = 5'h08;
   localparam [4:0] ST_SETL  = 5'h10;

   reg  [4:0]             state_reg;
   reg  [4:0]             state_next;
   reg  [3:0]             pcc_reg;
   reg  [3:0]             itm_reg;
   reg  [3:0]             ei0_reg;
   reg                    rst_load_reg;
   reg  [3:0]             aw_addr_reg;
   reg                    aw_have_reg;
   reg  [31:0]            w_data_reg;
   reg  [3:0]             w_strb_reg;
   reg                    w_have_reg;
   reg                    wait_load;
   reg  [`SMC_WAIT_W-1:0] wait_val;
   reg                    resume_next;
   wire                   wait_busy;
   wire                   wait_done;
   wire [`SMC_NSRC-1:0]   live_mask;
   wire [`SMC_NSRC-1:0]   fired;
   wire                   wake;
   wire                   wake_vec;
   wire                   wr_go;

   // Stop-mode wait picked by the interval timer mode field
   function [`SMC_WAIT_W-1:0] itm_wait;
      input [2:0] code;
      begin
         if (code == `SMC_ITM_W17)
            itm_wait = P_WAIT_17[`SMC_WAIT_W-1:0];
         else if (code == `SMC_ITM_W15)
            itm_wait = P_WAIT_15[`SMC_WAIT_W-1:0];
         else if (code == `SMC_ITM_W13)
            itm_wait = P_WAIT_13[`SMC_WAIT_W-1:0];
         else
            // Prohibited codes fall back to the longest, safest wait
            itm_wait = P_WAIT_20[`SMC_WAIT_W-1:0];
      end
   endfunction

   // Byte-lane merge of a 4-bit register from a 32-bit write
   function [3:0] lane_merge;
      input [3:0]  old;
      input [31:0] data;
      input [3:0]  strb;
      begin
         lane_merge = strb[0] ? data[3:0] : old;
      end
   endfunction

   // Sources still alive in stop mode; all are alive in halt mode
   // interval timer stopped
   assign live_mask[`SMC_SRC_BT]    = ~state_reg[3];
   assign live_mask[`SMC_SRC_EXT0]  = ~state_reg[3] | ei0_reg[`SMC_EI0_BYPASS_BIT];
   assign live_mask[`SMC_SRC_EXT1]  = 1'b1;
   assign live_mask[`SMC_SRC_EXT4]  = 1'b1;
   assign live_mask[`SMC_SRC_SER]   = ~state_reg[3] | i_ser_ext_clk_sel;
   assign live_mask[`SMC_SRC_TMR]   = ~state_reg[3] | i_tmr_ext_clk_sel;
   assign live_mask[`SMC_SRC_WATCH] = 1'b1;
   assign live_mask[`SMC_SRC_KEY]   = 1'b1;

   assign fired = i_irq_req & i_irq_en & live_mask;
   assign wake  = |fired;
   assign wake_vec = |(fired & ~((8'h01 << `SMC_SRC_WATCH) | (8'h01 << `SMC_SRC_KEY)));

   // Settling counter shared by reset and stop release
   smc_wait_cnt #(
      .W (`SMC_WAIT_W)
   ) u_wait (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .i_load    (wait_load),
      .i_count   (wait_val),
      .o_busy    (wait_busy),
      .o_done    (wait_done)
   );

   // Next state and counter load
   always @* begin
      state_next  = state_reg;
      wait_load   = 1'b0;
      wait_val    = itm_wait(itm_reg[2:0]);
      resume_next = 1'b0;
      case (state_reg)
         ST_RST: begin
            wait_val  = (P_RESET_LONG != 0) ? P_WAIT_17[`SMC_WAIT_W-1:0] : P_WAIT_15[`SMC_WAIT_W-1:0];
            wait_load = rst_load_reg;
            if (wait_done) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (i_stop_exec) begin
               // pending request turns stop into settling wait, oscillator kept
               if (wake) begin
                  wait_load  = 1'b1;
                  state_next = ST_SETL;
               end else begin
                  state_next = ST_STOP;
               end
            end else if (i_halt_exec) begin
               // pending request ends halt at once
               if (wake) begin
                  resume_next = 1'b1;
               end else begin
                  state_next = ST_HALT;
               end
            end
         end
         ST_HALT: begin
            if (wake) begin
               resume_next = 1'b1;
               state_next  = ST_RUN;
            end
         end
         ST_STOP: begin
            if (wake) begin
               wait_load  = 1'b1;
               state_next = ST_SETL;
            end
         end
         ST_SETL: begin
            if (wait_done) begin
               resume_next = 1'b1;
               state_next  = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RST;
         end
      endcase
   end

   // State and clock control register; reset forces the reset wait
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_reg    <= ST_RST;
         rst_load_reg <= 1'b1;
         pcc_reg      <= `SMC_PCC_RST;
      end else begin
         state_reg    <= state_next;
         rst_load_reg <= 1'b0;
         pcc_reg[`SMC_PCC_STOP_BIT] <= state_next[3] | (state_next[4] & state_reg != ST_RST);
         pcc_reg[`SMC_PCC_HALT_BIT] <= state_next[2];
         if (wr_go && aw_addr_reg == `SMC_OFS_CLK_CTRL && w_strb_reg[0]) begin
            // Only the clock select is software writable
            pcc_reg[1:0] <= w_data_reg[1:0];
         end
      end
   end

   // Registered block outputs
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_osc_en       <= 1'b1;
         o_cpu_clk_en   <= 1'b0;
         o_cpu_rst_hold <= 1'b1;
         o_retain       <= 1'b0;
         o_bt_run       <= 1'b1;
         o_ser_run      <= 1'b1;
         o_tmr_run      <= 1'b1;
         o_ext0_run     <= 1'b1;
         o_resume       <= 1'b0;
         o_vector_ok    <= 1'b0;
         o_cpu_clk_sel  <= 2'h0;
      end else begin
         o_osc_en       <= ~state_next[3];
         // CPU clock gated in every non-run state
         o_cpu_clk_en   <= state_next[1];
         o_cpu_rst_hold <= state_next[0];
         // freeze registers, memory and port latches
         o_retain       <= state_next[2] | state_next[3] | state_next[4];
         o_bt_run       <= ~state_next[3];
         // serial in stop only with external clock
         o_ser_run      <= ~state_next[3] | i_ser_ext_clk_sel;
         // timer in stop only with external input
         o_tmr_run      <= ~state_next[3] | i_tmr_ext_clk_sel;
         // interrupt 0 filter path stops in stop unless the noise eliminator bypass bit is set
         o_ext0_run     <= ~state_next[3] | ei0_reg[`SMC_EI0_BYPASS_BIT];
         o_resume       <= resume_next;
         // vector allowed only with master enable
         o_vector_ok    <= resume_next & i_master_irq_en & wake_vec;
         o_cpu_clk_sel  <= pcc_reg[1:0];
      end
   end

   // AXI write channels taken independently; response after both
   assign wr_go = aw_have_reg & w_have_reg & ~o_s_axi_bvalid;

   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         aw_have_reg     <= 1'b0;
         aw_addr_reg     <= 4'h0;
         w_have_reg      <= 1'b0;
         w_data_reg      <= 32'h0000_0000;
         w_strb_reg      <= 4'h0;
         o_s_axi_awready <= 1'b0;
         o_s_axi_wready  <= 1'b0;
         o_s_axi_bvalid  <= 1'b0;
         o_s_axi_bresp   <= `SMC_RESP_OKAY;
         itm_reg         <= `SMC_ITM_RST;
         ei0_reg         <= `SMC_EI0_RST;
      end else begin
         // Ready offered one cycle ahead, withdrawn while holding
         o_s_axi_awready <= ~aw_have_reg & ~(o_s_axi_awready & i_s_axi_awvalid);
         o_s_axi_wready  <= ~w_have_reg & ~(o_s_axi_wready & i_s_axi_wvalid);
         if (o_s_axi_awready && i_s_axi_awvalid) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= i_s_axi_awaddr;
         end
         if (o_s_axi_wready && i_s_axi_wvalid) begin
            w_have_reg <= 1'b1;
            w_data_reg <= i_s_axi_wdata;
            w_strb_reg <= i_s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_reg    <= 1'b0;
            w_have_reg     <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp  <= `SMC_RESP_OKAY;
            if (aw_addr_reg == `SMC_OFS_IT_MODE) begin
               // wait code stored for the next stop release
               itm_reg <= lane_merge(itm_reg, w_data_reg, w_strb_reg);
            end else if (aw_addr_reg == `SMC_OFS_EI0_MODE) begin
               ei0_reg <= lane_merge(ei0_reg, w_data_reg, w_strb_reg);
            end else if (aw_addr_reg == `SMC_OFS_CLK_CTRL) begin
               o_s_axi_bresp <= `SMC_RESP_OKAY;
            end else if (aw_addr_reg == `SMC_OFS_STATUS) begin
               o_s_axi_bresp <= `SMC_RESP_OKAY;
            end else begin
               o_s_axi_bresp <= `SMC_RESP_SLVERR;
            end
         end else if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI read: one outstanding read, answer the cycle after the address
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid  <= 1'b0;
         o_s_axi_rdata   <= 32'h0000_0000;
         o_s_axi_rresp   <= `SMC_RESP_OKAY;
      end else begin
         o_s_axi_arready <= ~o_s_axi_rvalid & ~(o_s_axi_arready & i_s_axi_arvalid);
         if (o_s_axi_arready && i_s_axi_arvalid) begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rresp  <= `SMC_RESP_OKAY;
            if (i_s_axi_araddr == `SMC_OFS_CLK_CTRL) begin
               o_s_axi_rdata <= {28'h0000000, pcc_reg};
            end else if (i_s_axi_araddr == `SMC_OFS_IT_MODE) begin
               o_s_axi_rdata <= {28'h0000000, itm_reg};
            end else if (i_s_axi_araddr == `SMC_OFS_EI0_MODE) begin
               o_s_axi_rdata <= {28'h0000000, ei0_reg};
            end else if (i_s_axi_araddr == `SMC_OFS_STATUS) begin
               // State one-hot, counter busy, live wake sources
               o_s_axi_rdata <= {18'h00000, fired, wait_busy, state_reg};
            end else begin
               o_s_axi_rdata <= 32'h0000_0000;
               o_s_axi_rresp <= `SMC_RESP_SLVERR;
            end
         end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// ---- rtl/smc_map.vh ----
// Constants for the standby mode controller: register offsets, field
// positions, reset values, wait codes and settling counts.
// Assumes it is included once per compile unit by its bare name.
`ifndef SMC_MAP_VH
`define SMC_MAP_VH

// Register byte offsets on the AXI4-Lite bus
`define SMC_OFS_CLK_CTRL   4'h0
`define SMC_OFS_IT_MODE    4'h4
`define SMC_OFS_EI0_MODE   4'h8
`define SMC_OFS_STATUS     4'hc

// Processor clock control fields
`define SMC_PCC_SEL_LO     0
`define SMC_PCC_SEL_HI     1
`define SMC_PCC_HALT_BIT   2
`define SMC_PCC_STOP_BIT   3

// External interrupt 0 edge mode: noise eliminator bypass bit
`define SMC_EI0_BYPASS_BIT 2

// Reset values
`define SMC_PCC_RST        4'h0
`define SMC_ITM_RST        4'h0
`define SMC_EI0_RST        4'h0

// Interval timer mode wait codes (low three bits)
`define SMC_ITM_W20        3'h0
`define SMC_ITM_W17        3'h3
`define SMC_ITM_W15        3'h5
`define SMC_ITM_W13        3'h7

// Settling counts in main clock periods
`define SMC_WAIT_20        21'h100000
`define SMC_WAIT_17        21'h020000
`define SMC_WAIT_15        21'h008000
`define SMC_WAIT_13        21'h002000
`define SMC_WAIT_W         21

// Interrupt source positions in the request and enable vectors
`define SMC_SRC_BT         0
`define SMC_SRC_EXT0       1
`define SMC_SRC_EXT1       2
`define SMC_SRC_EXT4       3
`define SMC_SRC_SER        4
`define SMC_SRC_TMR        5
`define SMC_SRC_WATCH      6
`define SMC_SRC_KEY        7
`define SMC_NSRC           8

// AXI responses
`define SMC_RESP_OKAY      2'h0
`define SMC_RESP_SLVERR    2'h2

`endif

// ---- rtl/smc_wait_cnt.v ----
// Settling wait counter: loads a count and pulses done when it expires.
// Assumes one clock; the count advances once per main clock period.
`timescale 1ns/1ns
module smc_wait_cnt #(
   parameter W = 21
) (
   input  wire         i_sys_clk,
   input  wire         i_sys_rst,
   input  wire         i_load,
   input  wire [W-1:0] i_count,
   output reg          o_busy,
   output reg          o_done
);
   reg [W-1:0] cnt_reg;

   // Down counter; a load restarts it even mid-count
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_reg <= {W{1'b0}};
         o_busy  <= 1'b0;
         o_done  <= 1'b0;
      end else if (i_load) begin
         cnt_reg <= i_count;
         o_busy  <= 1'b1;
         o_done  <= 1'b0;
      end else if (o_busy) begin
         // Done fires when the last of the loaded periods ends
         if (cnt_reg <= {{(W-1){1'b0}}, 1'b1}) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
         end else begin
            o_done <= 1'b0;
         end
         cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
      end else begin
         o_done <= 1'b0;
      end
   end
endmodule

// ---- testbench/smc_cpu_model.sv ----
// CPU side model: turns bench commands into standby instruction pulses.
// Assumes commands are one-cycle levels from the bench on the same clock.
`timescale 1ns/1ns
module smc_cpu_model #(
   parameter       P_EXT_CLK = 0,
   parameter [3:0] P_SW_WAIT = 4'h2
) (
   input  wire i_sys_clk,
   input  wire i_cmd_stop,
   input  wire i_cmd_halt,
   input  wire i_sel_change,
   output reg  o_stop_exec = 1'b0,
   output reg  o_halt_exec = 1'b0
);
   // Start values given at declaration so each output keeps a single driver
   reg [3:0] sw_cnt_reg = 4'h0;
   reg       nop_reg    = 1'b0;
   // instruction sequencing
   // A command in a NOP slot or clock switch is dropped, as a real core would not issue it
   always @(posedge i_sys_clk) begin
      o_stop_exec <= i_cmd_stop && !nop_reg && sw_cnt_reg == 4'h0 && P_EXT_CLK == 0;
      o_halt_exec <= i_cmd_halt && !nop_reg && sw_cnt_reg == 4'h0;
      nop_reg <= o_stop_exec || o_halt_exec; // NOP after each standby op
      sw_cnt_reg <= i_sel_change ? P_SW_WAIT : (sw_cnt_reg != 4'h0 ? sw_cnt_reg - 4'h1 : 4'h0);
   end
endmodule

// ---- testbench/smc_ctrl_sva.sv ----
// Checker for the standby controller: mode outputs against standby requests.
// Assumes it is bound to smc_ctrl and sees only that module's ports.
`timescale 1ns/1ns
`include "smc_map.vh"
module smc_ctrl_sva (
   input wire                 i_sys_clk,
   input wire                 i_sys_rst,
   input wire                 i_stop_exec,
   input wire                 i_halt_exec,
   input wire [`SMC_NSRC-1:0] i_irq_req,
   input wire [`SMC_NSRC-1:0] i_irq_en,
   input wire                 i_master_irq_en,
   input wire                 i_ser_ext_clk_sel,
   input wire                 i_tmr_ext_clk_sel,
   input wire                 o_osc_en,
   input wire                 o_cpu_clk_en,
   input wire                 o_cpu_rst_hold,
   input wire                 o_retain,
   input wire                 o_bt_run,
   input wire                 o_ser_run,
   input wire                 o_tmr_run,
   input wire                 o_ext0_run,
   input wire                 o_resume,
   input wire                 o_vector_ok
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // Enabled request from a source still alive; dead sources in stop never wake
   wire [`SMC_NSRC-1:0] live = {2'b11, o_osc_en | i_tmr_ext_clk_sel, o_osc_en | i_ser_ext_clk_sel,
                                2'b11, o_ext0_run, o_osc_en};
   wire wake = |(i_irq_req & i_irq_en & live);
   a_stop_freeze: assert property (!o_osc_en |-> !o_cpu_clk_en && o_retain && !o_bt_run)
      else $error("stop mode leaves logic running");
   a_run_no_retain: assert property (o_cpu_clk_en |-> !o_retain && o_osc_en)
      else $error("retain or oscillator wrong while running");
   a_stop_entry: assert property (o_cpu_clk_en && i_stop_exec && !wake |=> !o_osc_en)
      else $error("stop not entered");
   a_halt_entry: assert property (o_cpu_clk_en && i_halt_exec && !i_stop_exec && !wake
      |=> !o_cpu_clk_en && o_osc_en && o_retain) else $error("halt not entered");
   a_pending_exit: assert property (o_cpu_clk_en && i_halt_exec && !i_stop_exec && wake
      |=> o_resume && o_cpu_clk_en) else $error("pending wake did not exit");
   a_ser_in_stop: assert property (!o_osc_en && $past(!o_osc_en) |-> o_ser_run == $past(i_ser_ext_clk_sel))
      else $error("serial enable wrong in stop");
   a_tmr_in_stop: assert property (!o_osc_en && $past(!o_osc_en) |-> o_tmr_run == $past(i_tmr_ext_clk_sel))
      else $error("timer enable wrong in stop");
   a_vector_pair: assert property (o_vector_ok |-> o_resume && $past(i_master_irq_en))
      else $error("vector without resume or master enable");
   a_resume_pulse: assert property (o_resume |=> !o_resume)
      else $error("resume longer than one cycle");
   a_settle_bound: assert property ($rose(o_osc_en) && o_retain |-> ##[1:80] o_resume)
      else $error("settling wait overran");
   a_wake_exit: assert property (o_retain && wake |-> ##[1:80] o_resume)
      else $error("standby not left on wake");
   a_rst_hold: assert property (o_cpu_rst_hold |-> !o_cpu_clk_en && !o_retain)
      else $error("cpu runs during reset settle");
endmodule
bind smc_ctrl smc_ctrl_sva u_sva (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_stop_exec(i_stop_exec),
   .i_halt_exec(i_halt_exec), .i_irq_req(i_irq_req), .i_irq_en(i_irq_en), .i_master_irq_en(i_master_irq_en),
   .i_ser_ext_clk_sel(i_ser_ext_clk_sel), .i_tmr_ext_clk_sel(i_tmr_ext_clk_sel), .o_osc_en(o_osc_en),
   .o_cpu_clk_en(o_cpu_clk_en), .o_cpu_rst_hold(o_cpu_rst_hold), .o_retain(o_retain), .o_bt_run(o_bt_run),
   .o_ser_run(o_ser_run), .o_tmr_run(o_tmr_run), .o_ext0_run(o_ext0_run), .o_resume(o_resume),
   .o_vector_ok(o_vector_ok));

// ---- testbench/test_standby_mode_controller.sv ----
// Bench for the standby controller: registers over AXI4-Lite, stop and halt flows.
// Assumes small settling parameters; the CPU model supplies instruction pulses.
`timescale 1ns/1ns
`include "smc_map.vh"
module test_standby_mode_controller;
   reg         clk, rst, c_stop, c_halt, sel_chg, mie, ser_sel, tmr_sel, osc_drop;
   reg  [7:0]  req, en;
   reg  [3:0]  awaddr, araddr, wstrb;
   reg  [31:0] wdata, rd;
   reg         awvalid, wvalid, bready, arvalid, rready;
   wire        stop_x, halt_x, awready, wready, bvalid, arready, rvalid;
   wire [1:0]  bresp, rresp, clk_sel;
   wire [31:0] rdata;
   wire        osc_en, cpu_en, rst_hold, retain, bt_run, ser_run, tmr_run, ext0_run, resume, vec_ok;
   integer     err_count, samples_checked, i, n;
   localparam [11:0] CODES = 12'hf58;
   localparam [31:0] SRCS  = 32'h08048040;
   smc_ctrl #(.P_WAIT_20(64), .P_WAIT_17(32), .P_WAIT_15(16), .P_WAIT_13(8), .P_RESET_LONG(0)) DUT (
      .i_sys_clk(clk), .i_sys_rst(rst), .i_stop_exec(stop_x), .i_halt_exec(halt_x), .i_irq_req(req),
      .i_irq_en(en), .i_master_irq_en(mie), .i_ser_ext_clk_sel(ser_sel), .i_tmr_ext_clk_sel(tmr_sel),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
      .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
      .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
      .i_s_axi_rready(rready), .o_osc_en(osc_en), .o_cpu_clk_en(cpu_en), .o_cpu_rst_hold(rst_hold),
      .o_retain(retain), .o_bt_run(bt_run), .o_ser_run(ser_run), .o_tmr_run(tmr_run), .o_ext0_run(ext0_run),
      .o_resume(resume), .o_vector_ok(vec_ok), .o_cpu_clk_sel(clk_sel));
   smc_cpu_model MDL (.i_sys_clk(clk), .i_cmd_stop(c_stop), .i_cmd_halt(c_halt), .i_sel_change(sel_chg),
      .o_stop_exec(stop_x), .o_halt_exec(halt_x));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input [8*12:1] nm, input [31:0] e, input [31:0] g);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("BAD %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task chk_rng(input [8*12:1] nm, input integer lo, input integer hi, input integer g);
      begin
         samples_checked = samples_checked + 1;
         if (g < lo || g > hi) begin
            err_count = err_count + 1;
            $display("BAD %0s expected %0d to %0d seen %0d", nm, lo, hi, g);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("checked %0d mismatches %0d", samples_checked, err_count);
         if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // Both channels offered together, each dropped at its own handshake edge
   task axi_wr(input [3:0] a, input [3:0] d);
      reg ta, tw;
      begin
         @(posedge clk);
         awaddr <= a; wdata <= {28'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
         ta = 1'b0;
         tw = 1'b0;
         // Readies are registered, so the level seen mid-cycle is the one at the next edge
         while (!ta || !tw) begin
            @(negedge clk);
            ta = ta || awready === 1'b1;
            tw = tw || wready === 1'b1;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
         end
         while (bvalid !== 1'b1) @(negedge clk);
         chk("bresp", `SMC_RESP_OKAY, bresp);
         @(posedge clk);
         bready <= 1'b0;
      end
   endtask
   task axi_rd(input [3:0] a);
      reg ta;
      begin
         @(posedge clk);
         araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
         ta = 1'b0;
         while (!ta) begin
            @(negedge clk);
            ta = arready === 1'b1;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
         end
         while (rvalid !== 1'b1) @(negedge clk);
         rd = rdata;
         chk("rresp", `SMC_RESP_OKAY, rresp);
         @(posedge clk);
         rready <= 1'b0;
      end
   endtask
   task issue(input s);
      begin
         @(posedge clk);
         if (s) c_stop <= 1'b1; else c_halt <= 1'b1;
         @(posedge clk);
         c_stop <= 1'b0; c_halt <= 1'b0;
      end
   endtask
   // Counts cycles to the resume pulse and notes any oscillator drop meanwhile
   task wait_res;
      begin
         n = 0; osc_drop = 1'b0;
         while (resume !== 1'b1 && n < 300) begin
            @(negedge clk);
            n = n + 1;
            if (osc_en !== 1'b1) osc_drop = 1'b1;
         end
      end
   endtask
   task wait_cpu;
      begin
         n = 0;
         while (cpu_en !== 1'b1 && n < 300) begin
            @(negedge clk);
            n = n + 1;
         end
      end
   endtask
   task wake(input [7:0] src, input v, input integer lo, input integer hi);
      begin
         @(posedge clk);
         req <= src;
         wait_res;
         chk_rng("settle", lo, hi, n);
         chk("vector", v, vec_ok);
         @(posedge clk);
         req <= 8'h0;
      end
   endtask
   task t_reset;
      begin
         wait_cpu;
         chk_rng("rst wait", 16, 20, n);
         for (i = 0; i < 3; i = i + 1) begin
            axi_rd({i[1:0], 2'b00});
            chk("reset val", 32'h0, rd);
         end
         axi_wr(`SMC_OFS_STATUS, 4'hf);
         axi_rd(`SMC_OFS_STATUS);
         chk("status", 32'h2, rd & 32'h3f);
      end
   endtask
   task t_halt;
      begin
         axi_wr(`SMC_OFS_CLK_CTRL, 4'h1);
         @(posedge clk) sel_chg <= 1'b1;
         @(posedge clk) sel_chg <= 1'b0;
         repeat (4) @(negedge clk);
         chk("clk sel", 2'h1, clk_sel);
         issue(1'b0);
         repeat (4) @(negedge clk);
         chk("halt outs", 6'h1f, {cpu_en, osc_en, retain, bt_run, ser_run, tmr_run});
         axi_rd(`SMC_OFS_CLK_CTRL);
         chk("halt bit", 32'h5, rd);
         wake(8'h04, 1'b0, 1, 4);
      end
   endtask
   task t_stop_codes;
      begin
         @(posedge clk) mie <= 1'b1;
         for (i = 0; i < 4; i = i + 1) begin
            axi_wr(`SMC_OFS_IT_MODE, {1'b0, CODES[i*3+:3]});
            axi_wr(`SMC_OFS_EI0_MODE, i[0] ? 4'h4 : 4'h0);
            @(posedge clk);
            ser_sel <= i[0]; tmr_sel <= !i[0];
            issue(1'b1);
            repeat (4) @(negedge clk);
            chk("stop outs", 4'h2, {osc_en, cpu_en, retain, bt_run});
            chk("stop periph", {i[0], !i[0], i[0]}, {ser_run, tmr_run, ext0_run});
            axi_rd(`SMC_OFS_CLK_CTRL);
            chk("stop bit", 32'h9, rd);
            wake(SRCS[i*8+:8], i[1], 64 >> i, (64 >> i) + 4);
         end
      end
   endtask
   task t_pending;
      begin
         @(posedge clk) req <= 8'h08;
         issue(1'b0);
         wait_res;
         chk_rng("pend halt", 1, 6, n);
         chk("run kept", 1'b1, cpu_en);
         repeat (3) @(negedge clk);
         issue(1'b1);
         wait_res;
         chk("osc kept", 1'b0, osc_drop);
         chk_rng("pend stop", 8, 14, n);
         @(posedge clk) req <= 8'h0;
      end
   endtask
   task t_rst_standby;
      begin
         issue(1'b0);
         repeat (4) @(negedge clk);
         @(posedge clk) rst <= 1'b1;
         @(posedge clk) rst <= 1'b0;
         @(negedge clk);
         chk("rst hold", 2'h2, {rst_hold, retain});
         wait_cpu;
         chk_rng("rst wait", 16, 20, n);
         axi_rd(`SMC_OFS_CLK_CTRL);
         chk("ctrl reset", 32'h0, rd);
      end
   endtask
   initial begin
      err_count = 0; samples_checked = 0;
      rst = 1'b1; c_stop = 1'b0; c_halt = 1'b0; sel_chg = 1'b0; mie = 1'b0; ser_sel = 1'b0; tmr_sel = 1'b0;
      req = 8'h0; en = 8'hff; awaddr = 4'h0; araddr = 4'h0; wstrb = 4'hf; wdata = 32'h0;
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_halt;
      t_stop_codes;
      t_pending;
      t_rst_standby;
      end_of_test;
   end
   // Whole run needs a few hundred cycles; this cuts a hang short
   initial begin
      #200000;
      err_count = err_count + 1;
      end_of_test;
   end
endmodule
